// ==== spu_top.sv ====
// Protection unit: base decode, bus monitor, spurious vector, watchdog
// Functional notes
// - Supervisor-only write of base at C0F
// - Base readable only in debug mode
// - Reset clears valid bit only
// - Valid base compares upper 22 address bits
// - Masked address spaces go external
// - Monitor timeout raises transfer error
// - Error termination aborts current transfer
// - Timeout 128, 256, 512 or 1024
// - Count from start strobe to final ack
// - Internal cycles always monitored
// - Protection control written once only
// - Error on acknowledge gives vector 24
// - No pending level gives vector 24
// - Unanswered acknowledge gives access error
// - Watchdog timeout resets or interrupts
// - Watchdog reset sets cause bit
// - Reset output held 32 cycles
// - Watchdog vector stored 8 bits
// - Prescaler and timing bits set period
// - Service is 55 then AA
// - Watchdog served with stored vector
`timescale 1ns/1ps
module spu_top #(
  parameter int WD_EXP_BASE = 9,
  parameter int WD_EXP_PRE  = 9
) (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        CRM_WR,
  input  wire logic [11:0] CRM_LOC,
  input  wire logic        CRM_SUPV,
  input  wire logic [31:0] CRM_DATA,
  input  wire logic        DBG_MODE,
  input  wire logic        ACC_REQ,
  input  wire logic [31:0] ACC_ADDR,
  input  wire logic [4:0]  ACC_SPACE,
  input  wire logic        REG_WR,
  input  wire logic [1:0]  REG_SEL,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        TS_PIN,
  input  wire logic        TA_PIN,
  input  wire logic        ATA_PIN,
  input  wire logic        TEA_PIN,
  input  wire logic        CYC_INTERNAL,
  input  wire logic        CYC_LINE,
  input  wire logic        IACK_START,
  input  wire logic        IACK_PEND,
  input  wire logic        WDT_IACK,
  input  wire logic        RESET_OUT_PIN_SEL,
  output logic             INT_HIT,
  output logic             EXT_RUN,
  output logic [31:0]      DBG_BASE,
  output logic             CFG_LOCKED,
  output logic             BUS_ERROR,
  output logic             XFER_ABORT,
  output logic             VEC_VALID,
  output logic [7:0]       VEC_NUM,
  output logic             WDT_IRQ,
  output logic             SYS_RESET,
  output logic             RESET_OUT,
  output logic             WDT_RST_FLAG
);
  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic       ts_s, ta_s, ata_s, tea_s;
  // Two flops on every bus pin; only stage two is read
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else begin
      pin_s1_reg <= {TEA_PIN, ATA_PIN, TA_PIN, TS_PIN};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  assign {tea_s, ata_s, ta_s, ts_s} = pin_s2_reg;

  // ----------------------------------------------------------
  // State declarations
  // ----------------------------------------------------------
  logic [31:0]          pbase_reg, pbase_next;
  spu_pkg::spu_prot_type prot_reg, prot_next;
  logic                 locked_reg, locked_next;
  logic [7:0]           wvec_reg, wvec_next;
  logic                 hit_reg, hit_next, ext_reg, ext_next;
  logic [31:0]          dbg_reg, dbg_next;
  spu_pkg::spu_mon_type mon_reg, mon_next;
  logic [10:0]          mcnt_reg, mcnt_next;
  logic [2:0]           acks_reg, acks_next, need_reg, need_next;
  logic                 watch_reg, watch_next;
  logic                 iack_reg, iack_next;
  logic                 berr_reg, berr_next, abort_reg, abort_next;
  logic                 vv_reg, vv_next;
  logic [7:0]           vnum_reg, vnum_next;
  logic [31:0]          wcnt_reg, wcnt_next;
  logic                 armed_reg, armed_next, irq_reg, irq_next;
  logic [5:0]           rcnt_reg, rcnt_next;
  logic                 reset_out_pin_reg, reset_out_pin_next, flag_reg, flag_next;
  logic                 sysr_reg, sysr_next;
  logic [10:0]          bm_limit;
  logic [31:0]          wd_limit;
  logic                 masked, svc_done, wd_tmo, int_rst;

  // Limits: monitor 2^(10-bm_time), watchdog by prescale and time
  always_comb begin
    bm_limit = 11'(11'h001
               << (spu_pkg::BM_EXP_MAX - 4'(prot_reg.bm_time)));
    wd_limit = 32'((32'h0000_0001 << (WD_EXP_BASE + 2 * prot_reg.wd_time
               + (prot_reg.wd_pre ? WD_EXP_PRE : 0))) - 1);
  end
  assign masked   = |(pbase_reg[spu_pkg::MASK_LSB +: spu_pkg::MASK_W]
                      & ACC_SPACE);
  assign svc_done = REG_WR && REG_SEL == spu_pkg::SEL_SVC && armed_reg
                    && REG_WDATA == spu_pkg::SVC_SECOND;
  assign wd_tmo   = prot_reg.wd_en && wcnt_reg >= wd_limit && !svc_done;
  assign int_rst  = rcnt_reg == 6'h01;

  // ----------------------------------------------------------
  // Configuration and address decode
  // ----------------------------------------------------------
  always_comb begin
    pbase_next  = pbase_reg;
    prot_next   = prot_reg;
    locked_next = locked_reg;
    wvec_next   = wvec_reg;
    if (CRM_WR && CRM_SUPV && CRM_LOC == spu_pkg::PBASE_LOC)
      pbase_next = CRM_DATA;
    if (REG_WR && REG_SEL == spu_pkg::SEL_PROT && !locked_reg) begin
      prot_next   = spu_pkg::spu_prot_type'(REG_WDATA);
      locked_next = 1'b1;
    end
    if (REG_WR && REG_SEL == spu_pkg::SEL_VEC)
      wvec_next = REG_WDATA;
    // Internal watchdog reset clears valid bit, protection control and lock; stored vector keeps its value
    if (int_rst) begin
      pbase_next[spu_pkg::VALID_BIT] = 1'b0;
      prot_next   = spu_pkg::PROT_RESET;
      locked_next = 1'b0;
    end
    hit_next = ACC_REQ && pbase_reg[spu_pkg::VALID_BIT] && !masked
               && pbase_reg[31:spu_pkg::BASE_LSB]
                  == ACC_ADDR[31:spu_pkg::BASE_LSB];
    ext_next = ACC_REQ && !hit_next;
    dbg_next = DBG_MODE ? pbase_reg : 32'h0000_0000;
  end

  // Of the base register only the valid bit has a reset value; base stays as it was
  always_ff @(posedge MCLK) begin
    pbase_reg <= pbase_next;
    if (!RESETN) begin
      pbase_reg[spu_pkg::VALID_BIT] <= 1'b0;
      prot_reg   <= spu_pkg::PROT_RESET;
      locked_reg <= 1'b0;
      wvec_reg   <= spu_pkg::VEC_RESET;
      hit_reg    <= 1'b0;
      ext_reg    <= 1'b0;
      dbg_reg    <= 32'h0000_0000;
    end else begin
      prot_reg   <= prot_next;
      locked_reg <= locked_next;
      wvec_reg   <= wvec_next;
      hit_reg    <= hit_next;
      ext_reg    <= ext_next;
      dbg_reg    <= dbg_next;
    end
  end

  // ----------------------------------------------------------
  // Bus monitor and spurious vector
  // ----------------------------------------------------------
  always_comb begin
    mon_next   = mon_reg;
    mcnt_next  = mcnt_reg;
    acks_next  = acks_reg;
    need_next  = need_reg;
    watch_next = watch_reg;
    iack_next  = iack_reg;
    berr_next  = 1'b0;
    abort_next = 1'b0;
    vv_next    = 1'b0;
    vnum_next  = vnum_reg;
    if (IACK_START && !IACK_PEND) begin
      vv_next   = 1'b1;
      vnum_next = spu_pkg::SPUR_VEC;
    end else if (IACK_START) begin
      iack_next = 1'b1;
    end
    case (mon_reg)
      spu_pkg::SPU_IDLE: begin
        if (ts_s) begin
          mon_next   = spu_pkg::SPU_BUSY;
          mcnt_next  = 11'h000;
          acks_next  = 3'h0;
          need_next  = CYC_LINE ? spu_pkg::LINE_BEATS : spu_pkg::ONE_BEAT;
          watch_next = CYC_INTERNAL || prot_reg.bm_en || iack_next;
        end
      end
      spu_pkg::SPU_BUSY: begin
        mcnt_next = mcnt_reg + 11'h001;
        if (tea_s) begin
          mon_next   = spu_pkg::SPU_IDLE;
          abort_next = 1'b1;
          if (iack_reg) begin
            vv_next   = 1'b1;
            vnum_next = spu_pkg::SPUR_VEC;
            iack_next = 1'b0;
          end
        end else if (mcnt_reg >= bm_limit - 11'h001) begin
          // Unwatched cycles are released silently at the limit, so
          // the count never runs away and later starts are still seen
          mon_next  = spu_pkg::SPU_IDLE;
          berr_next = watch_reg;
          iack_next = 1'b0;
        end else if (ta_s || ata_s) begin
          acks_next = acks_reg + 3'h1;
          if (acks_reg + 3'h1 == need_reg) begin
            mon_next  = spu_pkg::SPU_IDLE;
            iack_next = 1'b0;
          end
        end
      end
      default: mon_next = spu_pkg::SPU_IDLE;
    endcase
    if (WDT_IACK && irq_reg) begin
      vv_next   = 1'b1;
      vnum_next = wvec_reg;
    end
  end

  // Registers of the monitor group
  always_ff @(posedge MCLK) begin
    if (!RESETN || int_rst) begin
      mon_reg   <= spu_pkg::SPU_IDLE;
      mcnt_reg  <= 11'h000;
      acks_reg  <= 3'h0;
      need_reg  <= 3'h1;
      watch_reg <= 1'b0;
      iack_reg  <= 1'b0;
      berr_reg  <= 1'b0;
      abort_reg <= 1'b0;
      vv_reg    <= 1'b0;
      vnum_reg  <= 8'h00;
    end else begin
      mon_reg   <= mon_next;
      mcnt_reg  <= mcnt_next;
      acks_reg  <= acks_next;
      need_reg  <= need_next;
      watch_reg <= watch_next;
      iack_reg  <= iack_next;
      berr_reg  <= berr_next;
      abort_reg <= abort_next;
      vv_reg    <= vv_next;
      vnum_reg  <= vnum_next;
    end
  end

  // ----------------------------------------------------------
  // Software watchdog and reset sequencer
  // ----------------------------------------------------------
  always_comb begin
    wcnt_next  = prot_reg.wd_en ? wcnt_reg + 32'h0000_0001 : 32'h0000_0000;
    armed_next = armed_reg;
    irq_next   = irq_reg;
    rcnt_next  = rcnt_reg == 6'h00 ? 6'h00 : rcnt_reg - 6'h01;
    reset_out_pin_next  = rcnt_next != 6'h00 && reset_out_pin_reg;
    flag_next  = flag_reg;
    // Other writes between the two steps keep the sequence armed
    if (REG_WR && REG_SEL == spu_pkg::SEL_SVC
        && REG_WDATA == spu_pkg::SVC_FIRST)
      armed_next = 1'b1;
    if (svc_done) begin
      armed_next = 1'b0;
      wcnt_next  = 32'h0000_0000;
      irq_next   = 1'b0;
    end
    if (wd_tmo) begin
      wcnt_next = 32'h0000_0000;
      if (prot_reg.wd_rst) begin
        rcnt_next = spu_pkg::RESET_OUT_PIN_CYCLES;
        reset_out_pin_next = RESET_OUT_PIN_SEL;
        flag_next = 1'b1;
      end else begin
        irq_next = 1'b1;
      end
    end
    if (int_rst) begin
      armed_next = 1'b0;
      irq_next   = 1'b0;
    end
    sysr_next = rcnt_next != 6'h00;
  end

  // Cause flag survives the internal reset, cleared only by RESETN
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      wcnt_reg  <= 32'h0000_0000;
      armed_reg <= 1'b0;
      irq_reg   <= 1'b0;
      rcnt_reg  <= 6'h00;
      reset_out_pin_reg  <= 1'b0;
      flag_reg  <= 1'b0;
      sysr_reg  <= 1'b0;
    end else begin
      wcnt_reg  <= wcnt_next;
      armed_reg <= armed_next;
      irq_reg   <= irq_next;
      rcnt_reg  <= rcnt_next;
      reset_out_pin_reg  <= reset_out_pin_next;
      flag_reg  <= flag_next;
      sysr_reg  <= sysr_next;
    end
  end

  // Outputs, all straight from flops
  assign INT_HIT      = hit_reg;
  assign EXT_RUN      = ext_reg;
  assign DBG_BASE     = dbg_reg;
  assign CFG_LOCKED   = locked_reg;
  assign BUS_ERROR    = berr_reg;
  assign XFER_ABORT   = abort_reg;
  assign VEC_VALID    = vv_reg;
  assign VEC_NUM      = vnum_reg;
  assign WDT_IRQ      = irq_reg;
  assign SYS_RESET    = sysr_reg;
  assign RESET_OUT    = reset_out_pin_reg;
  assign WDT_RST_FLAG = flag_reg;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  property p_valid_reset;
    disable iff (1'b0) !RESETN |=> !pbase_reg[spu_pkg::VALID_BIT];
  endproperty
  a_valid_reset: assert property (p_valid_reset)
    else $error("valid bit set after reset");

  property p_hit_cause;
    INT_HIT |-> $past(pbase_reg[31:spu_pkg::BASE_LSB])
                == $past(ACC_ADDR[31:spu_pkg::BASE_LSB]);
  endproperty
  a_hit_cause: assert property (p_hit_cause)
    else $error("hit without base match");

  property p_mask_ext;
    ACC_REQ && masked |=> EXT_RUN && !INT_HIT;
  endproperty
  a_mask_ext: assert property (p_mask_ext)
    else $error("masked access hit internally");

  property p_bm_range;
    mon_reg == spu_pkg::SPU_BUSY |-> mcnt_reg < bm_limit;
  endproperty
  a_bm_range: assert property (p_bm_range)
    else $error("monitor count beyond limit");

  property p_tea_abort;
    mon_reg == spu_pkg::SPU_BUSY && tea_s
      |=> XFER_ABORT && mon_reg == spu_pkg::SPU_IDLE;
  endproperty
  a_tea_abort: assert property (p_tea_abort)
    else $error("error termination did not abort");

  property p_lock;
    locked_reg && !int_rst |=> $stable(prot_reg);
  endproperty
  a_lock: assert property (p_lock)
    else $error("protection control changed after lock");

  property p_spur;
    IACK_START && !IACK_PEND && !(WDT_IACK && irq_reg) && !int_rst
      |=> VEC_VALID && VEC_NUM == spu_pkg::SPUR_VEC;
  endproperty
  a_spur: assert property (p_spur)
    else $error("no spurious vector for empty level");

  property p_reset_out_pin_len;
    $rose(SYS_RESET) |-> SYS_RESET [*8] ##24 SYS_RESET ##1 !SYS_RESET;
  endproperty
  a_reset_out_pin_len: assert property (p_reset_out_pin_len)
    else $error("reset not held 32 cycles");

  property p_svc_restart;
    svc_done && !wd_tmo |=> wcnt_reg == 32'h0000_0000 && !armed_reg;
  endproperty
  a_svc_restart: assert property (p_svc_restart)
    else $error("service did not restart count");

  property p_wd_irq;
    wd_tmo && !prot_reg.wd_rst && !int_rst |=> WDT_IRQ;
  endproperty
  a_wd_irq: assert property (p_wd_irq)
    else $error("watchdog timeout raised no interrupt");
endmodule : spu_top

// ==== spu_pkg.sv ====
// Shared constants and types for the system protection unit
package spu_pkg;
  // ----------------------------------------------------------
  // Peripheral base register layout
  // ----------------------------------------------------------
  localparam logic [11:0] PBASE_LOC = 12'h0c0f;
  localparam int          BASE_LSB  = 10;
  localparam int          VALID_BIT = 0;
  localparam int          MASK_LSB  = 1;
  localparam int          MASK_W    = 5;
  // ----------------------------------------------------------
  // Local register selects
  // ----------------------------------------------------------
  localparam logic [1:0] SEL_PROT = 2'h0;
  localparam logic [1:0] SEL_VEC  = 2'h1;
  localparam logic [1:0] SEL_SVC  = 2'h2;
  // ----------------------------------------------------------
  // Values and timing
  // ----------------------------------------------------------
  localparam logic [7:0]  SVC_FIRST   = 8'h55;
  localparam logic [7:0]  SVC_SECOND  = 8'haa;
  localparam logic [7:0]  SPUR_VEC    = 8'h18;
  localparam logic [7:0]  VEC_RESET   = 8'h0f;
  localparam logic [5:0]  RESET_OUT_PIN_CYCLES = 6'h20;
  localparam logic [2:0]  LINE_BEATS  = 3'h4;
  localparam logic [2:0]  ONE_BEAT    = 3'h1;
  localparam logic [3:0]  BM_EXP_MAX  = 4'ha;
  // ----------------------------------------------------------
  // Protection control fields
  // ----------------------------------------------------------
  typedef struct packed {
    logic       wd_en;
    logic       wd_rst;
    logic [1:0] wd_time;
    logic       wd_pre;
    logic       bm_en;
    logic [1:0] bm_time;
  } spu_prot_type;
  localparam spu_prot_type PROT_RESET = 8'h00;
  // Monitor states
  typedef enum logic [1:0] {
    SPU_IDLE = 2'b01,
    SPU_BUSY = 2'b10
  } spu_mon_type;
endpackage : spu_pkg

// ==== spu_bus_dev.sv ====
// Behavioural external bus device that answers cycle starts
`timescale 1ns/1ps
module spu_bus_dev (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] lat,
  input  wire logic [2:0] beats,
  output logic            ta,
  output logic            async_termination_ack,
  output logic            error_termination
);
  // ----------------------------------------------------------
  // Answer process
  // ----------------------------------------------------------
  // Mode 0 normal acks, 3 async acks, 1 error, 2 silent
  initial begin
    ta  = 1'b0;
    async_termination_ack = 1'b0;
    error_termination = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        repeat (lat) @(posedge clk);
        if (mode == 2'h0 || mode == 2'h3) begin
          repeat (beats) begin
            ta  <= !mode[0];
            async_termination_ack <= mode[0];
            @(posedge clk);
          end
        end else if (mode == 2'h1) begin
          error_termination <= 1'b1;
          @(posedge clk);
        end
        // Silent mode leaves the monitor to end it
        ta  <= 1'b0;
        async_termination_ack <= 1'b0;
        error_termination <= 1'b0;
      end
    end
  end
endmodule : spu_bus_dev

// ==== tb_top.sv ====
// Self-checking bench for the system protection unit
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------
  // Signals, inputs of the unit all given a value at time zero
  // ----------------------------------------------------------
  logic        MCLK = 1'b0, RESETN = 1'b0, CRM_WR = 1'b0, CRM_SUPV = 1'b0;
  logic        DBG_MODE = 1'b0, ACC_REQ = 1'b0, REG_WR = 1'b0;
  logic        TS_PIN = 1'b0, CYC_INTERNAL = 1'b0, CYC_LINE = 1'b0;
  logic        IACK_START = 1'b0, IACK_PEND = 1'b0, WDT_IACK = 1'b0;
  logic        RESET_OUT_PIN_SEL = 1'b0;
  logic [11:0] CRM_LOC = 12'h0000;
  logic [31:0] CRM_DATA = 32'h0000_0000, ACC_ADDR = 32'h0000_0000;
  logic [4:0]  ACC_SPACE = 5'h01, sp;
  logic [1:0]  REG_SEL = 2'h0, dev_mode = 2'h0;
  logic [7:0]  REG_WDATA = 8'h00, dev_lat = 8'h00, vn;
  logic [2:0]  dev_beats = 3'h1;
  logic        TA_PIN, ATA_PIN, TEA_PIN, INT_HIT, EXT_RUN, CFG_LOCKED;
  logic        BUS_ERROR, XFER_ABORT, VEC_VALID, WDT_IRQ, SYS_RESET;
  logic        RESET_OUT, WDT_RST_FLAG, be, ab, vv, hit;
  logic [31:0] DBG_BASE, addr, seed = 32'h0000_0285;
  logic [7:0]  VEC_NUM;
  int          fail_count = 0, checked = 0, n, i;
  localparam logic [31:0] BASE = 32'h1234_5c09;
  localparam logic [7:0]  SVC_SEQ [3] = '{8'h55, 8'h12, 8'haa};

  spu_top #(.WD_EXP_BASE(2), .WD_EXP_PRE(1)) u_dut (
    .MCLK(MCLK), .RESETN(RESETN), .CRM_WR(CRM_WR), .CRM_LOC(CRM_LOC),
    .CRM_SUPV(CRM_SUPV), .CRM_DATA(CRM_DATA), .DBG_MODE(DBG_MODE),
    .ACC_REQ(ACC_REQ), .ACC_ADDR(ACC_ADDR), .ACC_SPACE(ACC_SPACE),
    .REG_WR(REG_WR), .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA),
    .TS_PIN(TS_PIN), .TA_PIN(TA_PIN), .ATA_PIN(ATA_PIN), .TEA_PIN(TEA_PIN),
    .CYC_INTERNAL(CYC_INTERNAL), .CYC_LINE(CYC_LINE),
    .IACK_START(IACK_START), .IACK_PEND(IACK_PEND), .WDT_IACK(WDT_IACK),
    .RESET_OUT_PIN_SEL(RESET_OUT_PIN_SEL), .INT_HIT(INT_HIT), .EXT_RUN(EXT_RUN),
    .DBG_BASE(DBG_BASE), .CFG_LOCKED(CFG_LOCKED), .BUS_ERROR(BUS_ERROR),
    .XFER_ABORT(XFER_ABORT), .VEC_VALID(VEC_VALID), .VEC_NUM(VEC_NUM),
    .WDT_IRQ(WDT_IRQ), .SYS_RESET(SYS_RESET), .RESET_OUT(RESET_OUT),
    .WDT_RST_FLAG(WDT_RST_FLAG)
  );
  spu_bus_dev u_dev (
    .clk(MCLK), .start(TS_PIN), .mode(dev_mode), .lat(dev_lat),
    .beats(dev_beats), .ta(TA_PIN), .async_termination_ack(ATA_PIN), .error_termination(TEA_PIN)
  );

  // 20 MHz clock
  always #25 MCLK = ~MCLK;

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // A wait that ran out ends the run at once
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      fail_count++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      final_report;
    end
  endtask : bound

  task automatic tick;
    @(posedge MCLK);
    #1;
  endtask : tick

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic crm(input logic [31:0] d, input logic [11:0] loc,
                     input logic sv);
    @(posedge MCLK);
    CRM_WR   <= 1'b1;
    CRM_DATA <= d;
    CRM_LOC  <= loc;
    CRM_SUPV <= sv;
    @(posedge MCLK);
    CRM_WR <= 1'b0;
  endtask : crm

  task automatic reg_wr(input logic [1:0] sel, input logic [7:0] d);
    @(posedge MCLK);
    REG_WR    <= 1'b1;
    REG_SEL   <= sel;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask : reg_wr

  // One decode, answer seen the cycle after the request
  task automatic acc(input logic [31:0] a, input logic [4:0] s,
                     input logic h);
    @(posedge MCLK);
    ACC_REQ   <= 1'b1;
    ACC_ADDR  <= a;
    ACC_SPACE <= s;
    @(posedge MCLK);
    ACC_REQ <= 1'b0;
    #1;
    chk(INT_HIT, h);
    chk(EXT_RUN, !h);
  endtask : acc

  // One bus cycle, watched for 150 cycles whatever happens
  task automatic bus(input logic [1:0] md, input logic [7:0] lt,
                     input logic ln, input logic in, input logic ik);
    @(posedge MCLK);
    TS_PIN       <= 1'b1;
    CYC_LINE     <= ln;
    CYC_INTERNAL <= in;
    IACK_START   <= ik;
    dev_mode     <= md;
    dev_lat      <= lt;
    dev_beats    <= ln ? 3'h4 : 3'h1;
    @(posedge MCLK);
    TS_PIN     <= 1'b0;
    IACK_START <= 1'b0;
    n  = 0;
    be = 1'b0;
    ab = 1'b0;
    vv = 1'b0;
    for (int j = 1; j <= 150; j++) begin
      tick;
      if (n == 0 && (BUS_ERROR === 1'b1 || XFER_ABORT === 1'b1)) n = j;
      be = be | (BUS_ERROR === 1'b1);
      ab = ab | (XFER_ABORT === 1'b1);
      if (VEC_VALID === 1'b1) begin
        vv = 1'b1;
        vn = VEC_NUM;
      end
    end
    @(posedge MCLK);
    CYC_INTERNAL <= 1'b0;
  endtask : bus

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge MCLK);
    RESETN <= 1'b1;
    tick;
    chk(CFG_LOCKED, 1'b0);
    chk(WDT_RST_FLAG, 1'b0);
    acc(32'h1234_5c00, 5'h01, 1'b0);
    // User-mode and wrong-location writes must not take
    crm(BASE, 12'h0c0f, 1'b0);
    crm(BASE, 12'h0c0e, 1'b1);
    acc(32'h1234_5c00, 5'h01, 1'b0);
    crm(BASE, 12'h0c0f, 1'b1);
    acc(32'h1234_5fff, 5'h01, 1'b1);
    acc(32'h1234_6000, 5'h01, 1'b0);
    acc(32'h1234_5c10, 5'h04, 1'b0);
    // Random addresses, half inside the block; model decides the hit
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      addr = seed[0] ? {BASE[31:10], seed[10:1]} : seed;
      sp   = 5'h01 << (seed[20:18] % 5);
      hit  = addr[31:10] == BASE[31:10] && (sp & BASE[5:1]) == 5'h00;
      acc(addr, sp, hit);
    end
    @(posedge MCLK);
    DBG_MODE <= 1'b1;
    repeat (2) tick;
    chk(DBG_BASE, BASE);
    @(posedge MCLK);
    DBG_MODE <= 1'b0;
    repeat (2) tick;
    chk(DBG_BASE, 32'h0000_0000);
    // Irq mode, period 256, monitor on at 128; second write ignored
    reg_wr(spu_pkg::SEL_VEC, 8'h42);
    reg_wr(spu_pkg::SEL_PROT, 8'hb7);
    reg_wr(spu_pkg::SEL_PROT, 8'h00);
    tick;
    chk(CFG_LOCKED, 1'b1);
    bus(2'h2, 8'h00, 1'b0, 1'b0, 1'b0);
    chk(be, 1'b1);
    chk(n >= 126 && n <= 132, 1'b1);
    bus(2'h0, 8'h64, 1'b1, 1'b0, 1'b0);
    chk(be, 1'b0);
    bus(2'h3, 8'h64, 1'b1, 1'b0, 1'b0);
    chk(be, 1'b0);
    bus(2'h1, 8'h05, 1'b0, 1'b0, 1'b0);
    chk({ab, be}, 2'b10);
    // Acknowledge of a level with nothing pending
    @(posedge MCLK);
    IACK_START <= 1'b1;
    @(posedge MCLK);
    IACK_START <= 1'b0;
    IACK_PEND  <= 1'b1;
    #1;
    chk({VEC_VALID, VEC_NUM}, {1'b1, 8'h18});
    bus(2'h1, 8'h05, 1'b0, 1'b0, 1'b1);
    chk({vv, vn, ab}, {1'b1, 8'h18, 1'b1});
    bus(2'h2, 8'h05, 1'b0, 1'b0, 1'b1);
    chk({be, vv}, 2'b10);
    // Watchdog in interrupt mode
    reg_wr(spu_pkg::SEL_SVC, 8'h55);
    reg_wr(spu_pkg::SEL_SVC, 8'haa);
    repeat (200) tick;
    chk(WDT_IRQ, 1'b0);
    for (n = 0; n < 80 && WDT_IRQ !== 1'b1; n++) tick;
    bound(n, 80);
    @(posedge MCLK);
    WDT_IACK <= 1'b1;
    @(posedge MCLK);
    WDT_IACK <= 1'b0;
    #1;
    chk({VEC_VALID, VEC_NUM}, {1'b1, 8'h42});
    reg_wr(spu_pkg::SEL_SVC, 8'haa);
    tick;
    chk(WDT_IRQ, 1'b1);
    foreach (SVC_SEQ[k]) reg_wr(spu_pkg::SEL_SVC, SVC_SEQ[k]);
    tick;
    chk(WDT_IRQ, 1'b0);
    // Fresh reset, then watchdog in reset mode, monitor off
    @(posedge MCLK);
    RESETN <= 1'b0;
    repeat (5) @(posedge MCLK);
    RESETN   <= 1'b1;
    RESET_OUT_PIN_SEL <= 1'b1;
    tick;
    chk(WDT_RST_FLAG, 1'b0);
    acc(32'h1234_5c00, 5'h01, 1'b0);
    reg_wr(spu_pkg::SEL_PROT, 8'hf3);
    bus(2'h2, 8'h00, 1'b0, 1'b0, 1'b0);
    chk(be, 1'b0);
    reg_wr(spu_pkg::SEL_SVC, 8'h55);
    reg_wr(spu_pkg::SEL_SVC, 8'haa);
    bus(2'h2, 8'h00, 1'b0, 1'b1, 1'b0);
    chk(be, 1'b1);
    for (n = 0; n < 300 && SYS_RESET !== 1'b1; n++) tick;
    bound(n, 300);
    n = 1;
    i = (RESET_OUT === 1'b1);
    repeat (40) begin
      tick;
      n += (SYS_RESET === 1'b1);
      i += (RESET_OUT === 1'b1);
    end
    chk(n, 32);
    chk(i, 32);
    chk({WDT_RST_FLAG, CFG_LOCKED}, 2'b10);
    final_report;
  end
endmodule : tb_top
